/* pal_pkg.sv */
package pal_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int LINK_TIMEOUT_NS = 2000;
	localparam int LINK_TIMEOUT_CYC = (LINK_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OSC_PERIOD_NS = 1000;
	localparam int OSC_DIV_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int LATCH_PULSE_NS = 200;
	localparam int LATCH_PULSE_CYC = (LATCH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STRAP_SETTLE_CYC = 3;
	localparam int LOCK_VSYNCS = 2;
	localparam int BURNIN_LINES = 16;

	// ----------------------------------------
	// Data layout
	// ----------------------------------------
	localparam int COMP_W = 8;
	localparam int PIX_W = 3 * COMP_W;
	localparam int WORD_W = PIX_W + 1;
	localparam int PAIRS = 7;
	localparam int CLOCK_PAIR = 3;
	localparam int LAST_PAIR = PAIRS - 1;
	localparam int BUF_DEPTH = 8;
	localparam int MAX_SLOTS = 5;
	localparam int SLOTS_1024 = 3;
	localparam int SLOTS_1280 = 5;
	localparam int WIDTH_1024 = 1024;
	localparam int WIDTH_1280 = 1280;
	localparam int PATTERNS = 5;
	localparam logic [COMP_W-1:0] BLACK_ZERO = 8'h00;
	localparam logic [COMP_W-1:0] BLACK_ONE = 8'hFF;

	typedef enum logic {
		PAL_RES_1024,
		PAL_RES_1280
	} pal_res_t;

	typedef enum logic [1:0] {
		PAL_AUTO,
		PAL_NORMAL,
		PAL_BURNIN
	} pal_state_t;

endpackage : pal_pkg

/* pal_stream_if.sv */
interface pal_stream_if #(
	parameter int WIDTH = 25
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : pal_stream_if

/* pal_fifo.sv */
module pal_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// Streams
	pal_stream_if.snk wr,
	pal_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [AW:0] count;
	} pal_fifo_state_t;

	pal_fifo_state_t r_reg;
	pal_fifo_state_t r_next;
	logic push;
	logic pop;

	assign wr.ready = (r_reg.count != (AW+1)'(DEPTH));
	assign rd.valid = (r_reg.count != '0);
	assign rd.data = r_reg.mem[r_reg.rptr];
	assign push = wr.valid && wr.ready;
	assign pop = rd.valid && rd.ready;

	always_comb begin
		r_next = r_reg;
		if (push) begin
			r_next.mem[r_reg.wptr] = wr.data;
			r_next.wptr = (r_reg.wptr == AW'(DEPTH - 1)) ? '0 : r_reg.wptr + 1'b1;
		end
		if (pop) begin
			r_next.rptr = (r_reg.rptr == AW'(DEPTH - 1)) ? '0 : r_reg.rptr + 1'b1;
		end
		if (push && !pop) begin
			r_next.count = r_reg.count + 1'b1;
		end else if (pop && !push) begin
			r_next.count = r_reg.count - 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

endmodule : pal_fifo

/* pal_autorefresh_lane_map.sv */
module pal_autorefresh_lane_map #(
	parameter int FIFO_DEPTH = 8,
	parameter int FRAME_W = 16
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// Input link pins
	input wire logic i_link_clk,
	input wire logic i_link_de,
	input wire logic i_link_vsync,
	input wire logic [pal_pkg::PIX_W-1:0] i_link_data,
	output logic o_link_ready,
	output logic o_link_overflow,
	// Straps and configuration
	input wire logic i_burnin_b,
	input wire logic i_black_ones,
	input wire logic i_res_1280,
	input wire logic i_top_mount,
	input wire logic [FRAME_W-1:0] i_ar_frame_len,
	input wire logic [FRAME_W-1:0] i_ar_latch_pos,
	input wire logic [7:0] i_ar_gate_high,
	input wire logic [7:0] i_ar_gate_low,
	// Panel driver side
	input wire logic i_lane_ready,
	output logic o_lane_valid,
	output logic [pal_pkg::PAIRS-1:0][pal_pkg::COMP_W-1:0] o_right_pair,
	output logic [pal_pkg::PAIRS-1:0][pal_pkg::COMP_W-1:0] o_left_pair,
	output logic [pal_pkg::PAIRS-1:0] o_right_pair_on,
	output logic [pal_pkg::PAIRS-1:0] o_left_pair_on,
	output logic o_pair_clock,
	output logic o_source_latch_pulse,
	output logic o_gate_shift_clock,
	// Status
	output logic o_auto_refresh,
	output logic o_burnin
);
	localparam int CW = pal_pkg::COMP_W;
	localparam int NP = pal_pkg::PAIRS;
	localparam int BD = pal_pkg::BUF_DEPTH;

	typedef struct packed {
		logic [2:0] clk_sy;
		logic [1:0] de_sy;
		logic [1:0] vs_sy;
		logic [1:0] burn_sy;
		logic [1:0][pal_pkg::PIX_W-1:0] dat_sy;
		logic de_prev;
		logic vs_prev;
		logic [7:0] wd_cnt;
		logic [1:0] settle;
		logic strap_done;
		pal_pkg::pal_state_t state;
		logic [1:0] lock_cnt;
		logic [10:0] pix_cnt;
		logic [10:0] burn_px;
		logic [4:0] burn_line;
		logic [2:0] pattern;
		logic [BD-1:0][CW-1:0] cbuf;
		logic [BD-1:0] cside;
		logic [3:0] ccnt;
		logic [7:0] osc_div;
		logic [FRAME_W-1:0] frame_cnt;
		logic [7:0] gate_cnt;
		logic [3:0] pulse_cnt;
		logic overflow;
		logic lane_valid;
		logic [NP-1:0][CW-1:0] right;
		logic [NP-1:0][CW-1:0] left;
		logic [NP-1:0] right_on;
		logic [NP-1:0] left_on;
		logic pair_clock;
		logic latch;
		logic gate;
	} pal_state_reg_t;

	pal_state_reg_t r_reg;
	pal_state_reg_t r_next;

	pal_stream_if #(.WIDTH(pal_pkg::WORD_W)) wr_if ();
	pal_stream_if #(.WIDTH(pal_pkg::WORD_W)) rd_if ();

	pal_fifo #(.WIDTH(pal_pkg::WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.wr(wr_if.snk),
		.rd(rd_if.src)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [2:0] slot_pair(input logic res_1280, input int slot,
			input logic top);
		logic [2:0] p;
		p = 3'(slot);
		if (res_1280) begin
			case (slot)
				0: p = 3'h0;
				1: p = 3'h1;
				2: p = 3'h4;
				3: p = 3'h5;
				default: p = 3'h6;
			endcase
		end else begin
			case (slot)
				0: p = 3'h1;
				1: p = 3'h4;
				default: p = 3'h6;
			endcase
		end
		if (top) begin
			p = 3'(pal_pkg::LAST_PAIR) - p;
		end
		return p;
	endfunction : slot_pair

	function automatic logic [pal_pkg::PIX_W-1:0] pattern_color(input logic [2:0] idx);
		case (idx)
			3'h0: return 24'h000000;
			3'h1: return 24'hFFFFFF;
			3'h2: return 24'hFF0000;
			3'h3: return 24'h00FF00;
			default: return 24'h0000FF;
		endcase
	endfunction : pattern_color

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic link_edge;
	logic alive;
	logic de_now;
	logic sol;
	logic push;
	logic [pal_pkg::PIX_W-1:0] push_pix;
	logic osc_tick;
	logic [3:0] nslots;
	logic [10:0] half;
	logic [10:0] pidx;
	logic [2:0] p;
	logic [CW-1:0] black;
	logic emit;
	logic [NP-1:0] mask;

	assign wr_if.valid = push;
	assign wr_if.data = {sol, push_pix};
	assign rd_if.ready = (r_reg.state == pal_pkg::PAL_AUTO) ||
		(r_reg.ccnt <= 4'(BD - pal_pkg::SLOTS_1024));
	assign link_edge = r_reg.clk_sy[1] && !r_reg.clk_sy[2];
	assign alive = r_reg.wd_cnt < 8'(pal_pkg::LINK_TIMEOUT_CYC);
	assign de_now = r_reg.de_sy[1];
	assign osc_tick = r_reg.osc_div == 8'(pal_pkg::OSC_DIV_CYC - 1);
	assign nslots = i_res_1280 ? 4'(pal_pkg::SLOTS_1280) : 4'(pal_pkg::SLOTS_1024);
	assign half = i_res_1280 ? 11'(pal_pkg::WIDTH_1280 / 2) : 11'(pal_pkg::WIDTH_1024 / 2);
	assign black = i_black_ones ? pal_pkg::BLACK_ONE : pal_pkg::BLACK_ZERO;

	always_comb begin
		r_next = r_reg;
		push = 1'b0;
		sol = 1'b0;
		push_pix = r_reg.dat_sy[1];
		emit = 1'b0;
		pidx = '0;
		p = '0;
		mask = '0;
		r_next.clk_sy = {r_reg.clk_sy[1:0], i_link_clk};
		r_next.de_sy = {r_reg.de_sy[0], i_link_de};
		r_next.vs_sy = {r_reg.vs_sy[0], i_link_vsync};
		r_next.burn_sy = {r_reg.burn_sy[0], i_burnin_b};
		r_next.dat_sy = {r_reg.dat_sy[0], i_link_data};
		r_next.lane_valid = 1'b0;

		// Link watchdog: missing clock edges means an abnormal input
		if (link_edge) begin
			r_next.wd_cnt = '0;
		end else if (alive) begin
			r_next.wd_cnt = r_reg.wd_cnt + 1'b1;
		end

		// Strap is caught once the synchroniser has settled
		if (!r_reg.strap_done) begin
			r_next.settle = r_reg.settle + 1'b1;
			if (r_reg.settle == 2'(pal_pkg::STRAP_SETTLE_CYC - 1)) begin
				r_next.strap_done = 1'b1;
				if (!r_reg.burn_sy[1]) begin
					r_next.state = pal_pkg::PAL_BURNIN;
				end
			end
		end

		case (r_reg.state)
			pal_pkg::PAL_AUTO: begin
				if (!alive) begin
					r_next.lock_cnt = '0;
				end else if (link_edge && r_reg.vs_sy[1] && !r_reg.vs_prev) begin
					r_next.lock_cnt = r_reg.lock_cnt + 1'b1;
					if (r_reg.lock_cnt == 2'(pal_pkg::LOCK_VSYNCS - 1) && r_reg.strap_done &&
							r_reg.burn_sy[1]) begin
						r_next.state = pal_pkg::PAL_NORMAL;
					end
				end
			end
			pal_pkg::PAL_NORMAL: begin
				if (!alive) begin
					r_next.state = pal_pkg::PAL_AUTO;
					r_next.lock_cnt = '0;
					r_next.ccnt = '0;
				end else if (link_edge) begin
					push = de_now;
					sol = de_now && !r_reg.de_prev;
					if (!de_now && r_reg.de_prev) begin
						r_next.pulse_cnt = 4'(pal_pkg::LATCH_PULSE_CYC);
					end
				end
			end
			pal_pkg::PAL_BURNIN: begin
				if (link_edge) begin
					push = 1'b1;
					sol = (r_reg.burn_px == '0);
					push_pix = pattern_color(r_reg.pattern);
					r_next.burn_px = r_reg.burn_px + 1'b1;
					if (r_reg.burn_px == (half << 1) - 1'b1) begin
						r_next.burn_px = '0;
						r_next.pulse_cnt = 4'(pal_pkg::LATCH_PULSE_CYC);
						r_next.burn_line = r_reg.burn_line + 1'b1;
						if (r_reg.burn_line == 5'(pal_pkg::BURNIN_LINES - 1)) begin
							r_next.burn_line = '0;
							r_next.pattern = (r_reg.pattern == 3'(pal_pkg::PATTERNS - 1)) ?
								'0 : r_reg.pattern + 1'b1;
						end
					end
				end
			end
			default: r_next.state = pal_pkg::PAL_AUTO;
		endcase
		if (link_edge) begin
			r_next.de_prev = de_now;
			r_next.vs_prev = r_reg.vs_sy[1];
		end
		if (push && !wr_if.ready) begin
			r_next.overflow = 1'b1;
		end

		if (r_reg.state == pal_pkg::PAL_AUTO) begin
			// Internal oscillator timebase
			r_next.osc_div = osc_tick ? '0 : r_reg.osc_div + 1'b1;
			r_next.ccnt = '0;
			if (osc_tick) begin
				r_next.frame_cnt = (r_reg.frame_cnt >= i_ar_frame_len - 1'b1) ?
					'0 : r_reg.frame_cnt + 1'b1;
				r_next.latch = (r_reg.frame_cnt == i_ar_latch_pos);
				if (r_reg.gate_cnt == (r_reg.gate ? i_ar_gate_high : i_ar_gate_low)) begin
					r_next.gate = !r_reg.gate;
					r_next.gate_cnt = '0;
				end else begin
					r_next.gate_cnt = r_reg.gate_cnt + 1'b1;
				end
				if (i_lane_ready) begin
					emit = 1'b1;
					for (int k = 0; k < pal_pkg::MAX_SLOTS; k++) begin
						if (4'(k) < nslots) begin
							p = slot_pair(i_res_1280, k, i_top_mount);
							r_next.right[p] = black;
							r_next.left[p] = black;
							mask[p] = 1'b1;
						end
					end
				end
			end
		end else begin
			r_next.osc_div = '0;
			r_next.frame_cnt = '0;
			r_next.gate_cnt = '0;
			r_next.latch = (r_reg.pulse_cnt != '0);
			r_next.gate = (r_reg.pulse_cnt != '0);
			if (r_reg.pulse_cnt != '0) begin
				r_next.pulse_cnt = r_reg.pulse_cnt - 1'b1;
			end
			// Emit one symbol when enough components are queued
			if (i_lane_ready && r_reg.ccnt >= nslots) begin
				emit = 1'b1;
				for (int k = 0; k < pal_pkg::MAX_SLOTS; k++) begin
					if (4'(k) < nslots) begin
						p = slot_pair(i_res_1280, k, i_top_mount);
						if (r_reg.cside[0] ^ i_top_mount) begin
							r_next.left[p] = r_reg.cbuf[k];
						end else begin
							r_next.right[p] = r_reg.cbuf[k];
						end
						mask[p] = 1'b1;
					end
				end
				for (int k = 0; k < BD; k++) begin
					r_next.cbuf[k] = (4'(k) + nslots < 4'(BD)) ?
						r_reg.cbuf[3'(4'(k) + nslots)] : '0;
					r_next.cside[k] = (4'(k) + nslots < 4'(BD)) ?
						r_reg.cside[3'(4'(k) + nslots)] : 1'b0;
				end
				r_next.ccnt = r_reg.ccnt - nslots;
			end
			// Append only a word the FIFO really pops, so a held word never repeats
			if (rd_if.valid && rd_if.ready) begin
				pidx = rd_if.data[pal_pkg::PIX_W] ? '0 : r_reg.pix_cnt + 1'b1;
				r_next.pix_cnt = pidx;
				for (int c = 0; c < 3; c++) begin
					r_next.cbuf[3'(r_next.ccnt + 4'(c))] =
						rd_if.data[pal_pkg::PIX_W - 1 - c * CW -: CW];
					r_next.cside[3'(r_next.ccnt + 4'(c))] = (pidx >= half);
				end
				r_next.ccnt = r_next.ccnt + 4'h3;
			end
		end

		if (emit) begin
			r_next.lane_valid = 1'b1;
			r_next.pair_clock = !r_reg.pair_clock;
			// Unused pairs powered down; clock pair on from the first symbol after reset
			r_next.right_on = mask | NP'(1 << pal_pkg::CLOCK_PAIR);
			r_next.left_on = mask | NP'(1 << pal_pkg::CLOCK_PAIR);
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_link_ready = wr_if.ready;
	assign o_link_overflow = r_reg.overflow;
	assign o_lane_valid = r_reg.lane_valid;
	assign o_right_pair = r_reg.right;
	assign o_left_pair = r_reg.left;
	assign o_right_pair_on = r_reg.right_on;
	assign o_left_pair_on = r_reg.left_on;
	assign o_pair_clock = r_reg.pair_clock;
	assign o_source_latch_pulse = r_reg.latch;
	assign o_gate_shift_clock = r_reg.gate;
	assign o_auto_refresh = (r_reg.state == pal_pkg::PAL_AUTO);
	assign o_burnin = (r_reg.state == pal_pkg::PAL_BURNIN);

endmodule : pal_autorefresh_lane_map

/* pal_autorefresh_lane_map_assertions.sv */
// ----
// Port checker
// ----
module pal_lane_chk #(
	parameter int FRAME_W = 16
) (
	// Clock, reset and inputs
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_link_clk,
	input wire logic i_link_vsync,
	input wire logic i_black_ones,
	input wire logic i_res_1280,
	input wire logic i_top_mount,
	input wire logic [FRAME_W-1:0] i_ar_frame_len,
	input wire logic [7:0] i_ar_gate_high,
	input wire logic [7:0] i_ar_gate_low,
	input wire logic i_lane_ready,
	// Outputs watched
	input wire logic o_lane_valid,
	input wire logic [pal_pkg::PAIRS-1:0][pal_pkg::COMP_W-1:0] o_right_pair,
	input wire logic [pal_pkg::PAIRS-1:0][pal_pkg::COMP_W-1:0] o_left_pair,
	input wire logic [pal_pkg::PAIRS-1:0] o_right_pair_on,
	input wire logic [pal_pkg::PAIRS-1:0] o_left_pair_on,
	input wire logic o_pair_clock,
	input wire logic o_source_latch_pulse,
	input wire logic o_gate_shift_clock,
	input wire logic o_auto_refresh,
	input wire logic o_burnin
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	int gap_reg, run_reg, sil_reg, vs_reg;
	logic lseen_reg, gseen_reg, lclk_reg, vsp_reg, lat_reg, gate_reg;
	// Seen flags skip the partial run on entry to auto-refresh
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			{lseen_reg, gseen_reg, lclk_reg, vsp_reg, lat_reg, gate_reg} <= '0;
			{gap_reg, run_reg, sil_reg, vs_reg} <= '0;
		end else begin
			lclk_reg <= i_link_clk;
			vsp_reg <= i_link_vsync;
			lat_reg <= o_source_latch_pulse;
			gate_reg <= o_gate_shift_clock;
			gap_reg <= (o_source_latch_pulse && !lat_reg) ? 1 : gap_reg + 1;
			lseen_reg <= o_auto_refresh && (lseen_reg || (o_source_latch_pulse && !lat_reg));
			run_reg <= (o_gate_shift_clock != gate_reg) ? 1 : run_reg + 1;
			gseen_reg <= o_auto_refresh && (gseen_reg || o_gate_shift_clock != gate_reg);
			sil_reg <= (i_link_clk && !lclk_reg) ? 0 : (sil_reg < 99 ? sil_reg + 1 : sil_reg);
			vs_reg <= !o_auto_refresh ? 0 : vs_reg + 32'(i_link_vsync && !vsp_reg);
		end
	end
	function automatic logic blk_ok(input logic [pal_pkg::PAIRS-1:0][pal_pkg::COMP_W-1:0] d,
		input logic [pal_pkg::PAIRS-1:0] on, input logic b);
		for (int p = 0; p < pal_pkg::PAIRS; p++)
			if (p != pal_pkg::CLOCK_PAIR && on[p] && d[p] != {pal_pkg::COMP_W{b}})
				return 1'b0;
		return 1'b1;
	endfunction : blk_ok
	function automatic logic [6:0] exp_mask(input logic res, input logic top);
		return res ? (top ? 7'h67 : 7'h73) : (top ? 7'h25 : 7'h52);
	endfunction : exp_mask
	property p_reset_auto;
		$rose(i_rst_b) |-> o_auto_refresh;
	endproperty
	a_reset_auto: assert property (p_reset_auto) else $error("no auto-refresh after reset");
	property p_black;
		o_lane_valid && o_auto_refresh |-> blk_ok(o_right_pair, o_right_pair_on,
			$past(i_black_ones)) && blk_ok(o_left_pair, o_left_pair_on, $past(i_black_ones));
	endproperty
	a_black: assert property (p_black) else $error("auto-refresh data not black");
	property p_mask;
		o_lane_valid |-> ((o_right_pair_on | o_left_pair_on) & 7'h77) ==
			exp_mask($past(i_res_1280), $past(i_top_mount));
	endproperty
	a_mask: assert property (p_mask) else $error("pair power mask wrong");
	property p_pclk;
		o_lane_valid |-> o_pair_clock != $past(o_pair_clock);
	endproperty
	a_pclk: assert property (p_pclk) else $error("pair clock did not toggle");
	property p_valid_rdy;
		o_lane_valid |-> $past(i_lane_ready);
	endproperty
	a_valid_rdy: assert property (p_valid_rdy) else $error("symbol without ready");
	property p_latch_gap;
		o_auto_refresh && lseen_reg && $rose(o_source_latch_pulse) |->
			gap_reg == i_ar_frame_len * pal_pkg::OSC_DIV_CYC;
	endproperty
	a_latch_gap: assert property (p_latch_gap) else $error("latch spacing wrong");
	property p_gate_run;
		o_auto_refresh && gseen_reg && $changed(o_gate_shift_clock) |-> run_reg ==
			(($past(o_gate_shift_clock) ? i_ar_gate_high : i_ar_gate_low) + 1) *
			pal_pkg::OSC_DIV_CYC;
	endproperty
	a_gate_run: assert property (p_gate_run) else $error("gate clock phase wrong");
	property p_silent;
		sil_reg == 50 && !o_burnin |-> o_auto_refresh;
	endproperty
	a_silent: assert property (p_silent) else $error("silent link kept normal");
	property p_lock;
		$fell(o_auto_refresh) |-> o_burnin || vs_reg >= 2;
	endproperty
	a_lock: assert property (p_lock) else $error("left auto-refresh unlocked");
	property p_burnin_hold;
		o_burnin |=> o_burnin;
	endproperty
	a_burnin_hold: assert property (p_burnin_hold) else $error("burn-in left");
	c_latch: cover property (o_auto_refresh && lseen_reg && $rose(o_source_latch_pulse));
	c_normal: cover property (o_lane_valid && !o_auto_refresh);
	c_burnin: cover property (o_burnin && o_lane_valid);
endmodule : pal_lane_chk

bind pal_autorefresh_lane_map pal_lane_chk #(.FRAME_W(FRAME_W)) i_chk (.i_clock, .i_rst_b,
	.i_link_clk, .i_link_vsync, .i_black_ones, .i_res_1280, .i_top_mount, .i_ar_frame_len,
	.i_ar_gate_high, .i_ar_gate_low, .i_lane_ready, .o_lane_valid, .o_right_pair, .o_left_pair,
	.o_right_pair_on, .o_left_pair_on, .o_pair_clock, .o_source_latch_pulse,
	.o_gate_shift_clock, .o_auto_refresh, .o_burnin);

/* pal_panel_model.sv */
// ----
// Column and gate driver model
// ----
module pal_panel_model (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// Behaviour
	input wire logic i_stall,
	input wire logic i_slow,
	// Lane handshake
	output logic o_lane_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	int seed = 32'h7307;
	initial o_lane_ready = 1'b0;
	// Slow mode drops ready at random to exercise buffering
	always @(posedge i_clock) begin
		#2;
		o_lane_ready = i_rst_b && !i_stall && (!i_slow || ($random(seed) & 1));
	end
endmodule : pal_panel_model

/* tb_pal_autorefresh_lane_map.sv */
module tb_pal_autorefresh_lane_map;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'b0, i_rst_b = 1'b0, i_link_clk = 1'b0, i_link_de = 1'b0;
	logic i_link_vsync = 1'b0, i_burnin_b = 1'b1, i_black_ones = 1'b0;
	logic i_res_1280 = 1'b0, i_top_mount = 1'b0, i_lane_ready;
	logic [pal_pkg::PIX_W-1:0] i_link_data = '0;
	logic [15:0] i_ar_frame_len = 16'h0006, i_ar_latch_pos = 16'h0002;
	logic [7:0] i_ar_gate_high = 8'h01, i_ar_gate_low = 8'h02;
	logic stall = 1'b0, slow = 1'b0, link_on = 1'b0, chk_on = 1'b1;
	logic o_link_ready, o_link_overflow, o_lane_valid, o_pair_clock, o_source_latch_pulse;
	logic o_gate_shift_clock, o_auto_refresh, o_burnin;
	logic [pal_pkg::PAIRS-1:0][pal_pkg::COMP_W-1:0] o_right_pair, o_left_pair;
	logic [pal_pkg::PAIRS-1:0] o_right_pair_on, o_left_pair_on;
	int n_fail = 0, cmp_count = 0, seed = 32'h7307, cyc = 0, nsym = 0;
	logic [7:0] exp_q[$];
	pal_autorefresh_lane_map #(.FIFO_DEPTH(pal_pkg::BUF_DEPTH), .FRAME_W(16)) i_dut (.i_clock,
		.i_rst_b, .i_link_clk, .i_link_de, .i_link_vsync, .i_link_data, .o_link_ready,
		.o_link_overflow, .i_burnin_b, .i_black_ones, .i_res_1280, .i_top_mount,
		.i_ar_frame_len, .i_ar_latch_pos, .i_ar_gate_high, .i_ar_gate_low, .i_lane_ready,
		.o_lane_valid, .o_right_pair, .o_left_pair, .o_right_pair_on, .o_left_pair_on,
		.o_pair_clock, .o_source_latch_pulse, .o_gate_shift_clock, .o_auto_refresh, .o_burnin);
	pal_panel_model i_drv (.i_clock, .i_rst_b, .i_stall(stall), .i_slow(slow),
		.o_lane_ready(i_lane_ready));
	always #25 i_clock = ~i_clock;
	// Link clock stands low while the host is silent
	initial begin
		#7;
		forever #200 i_link_clk = link_on ? ~i_link_clk : 1'b0;
	end
	task finish_test();
		if (n_fail == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	task check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : check
	task tick(input int n);
		repeat (n) @(posedge i_clock);
		#2;
	endtask : tick
	task link_step();
		@(negedge i_link_clk);
		tick(1);
	endtask : link_step
	task wait_auto(input logic v);
		for (int k = 0; k < 300 && o_auto_refresh !== v; k++)
			tick(1);
	endtask : wait_auto
	function automatic int slot_pair(input int s);
		int p;
		p = i_res_1280 ? (s < 2 ? s : s + 2) : (s == 0 ? 1 : 2 * s + 2);
		return i_top_mount ? 6 - p : p;
	endfunction : slot_pair
	task send_line(input int n);
		logic [23:0] d;
		for (int i = 0; i < n; i++) begin
			d = 24'($random(seed));
			link_step();
			i_link_de = 1'b1;
			i_link_data = d;
			exp_q.push_back(d[23:16]);
			exp_q.push_back(d[15:8]);
			exp_q.push_back(d[7:0]);
		end
		link_step();
		i_link_de = 1'b0;
		i_link_data = ~d;
	endtask : send_line
	task lock();
		link_on = 1'b1;
		repeat (4) link_step();
		repeat (2) begin
			i_link_vsync = 1'b1;
			repeat (2) link_step();
			i_link_vsync = 1'b0;
			repeat (2) link_step();
		end
		wait_auto(1'b0);
		exp_q.delete();
	endtask : lock
	task do_reset(input logic strap);
		i_rst_b = 1'b0;
		i_burnin_b = strap;
		tick(5);
		i_rst_b = 1'b1;
		tick(1);
	endtask : do_reset
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			finish_test();
		end
	end
	// ----
	// Reference model of the lane mapping
	// ----
	always @(posedge i_clock) begin : mon
		int n;
		logic pop;
		n = i_res_1280 ? 5 : 3;
		pop = !o_auto_refresh && exp_q.size() >= n;
		if (o_lane_valid)
			nsym++;
		if (o_lane_valid && chk_on)
			for (int s = 0; s < n; s++) begin
				if (o_auto_refresh) begin
					check(o_right_pair[slot_pair(s)], {8{i_black_ones}});
					check(o_left_pair[slot_pair(s)], {8{i_black_ones}});
				end else if (o_burnin) begin
					// First burn-in colour is black, on the near half
					check(o_right_pair[slot_pair(s)], 8'h00);
				end else if (pop) begin
					check(i_top_mount ? o_left_pair[slot_pair(s)] : o_right_pair[slot_pair(s)],
						exp_q.pop_front());
				end
			end
	end
	initial begin
		for (int c = 0; c < 4; c++) begin
			link_on = 1'b0;
			i_res_1280 = c[0];
			i_top_mount = c[1];
			i_black_ones = c[0];
			slow = c[1];
			do_reset(1'b1);
			check(o_auto_refresh, 1);
			nsym = 0;
			tick(400);
			check(o_auto_refresh, 1);
			check(nsym > 0, 1);
			lock();
			check(o_auto_refresh, 0);
			send_line(10);
			tick(150);
			check(exp_q.size(), 0);
			link_on = 1'b0;
			wait_auto(1'b1);
			check(o_auto_refresh, 1);
		end
		{i_res_1280, i_top_mount, slow} = 3'h0;
		do_reset(1'b1);
		lock();
		chk_on = 1'b0;
		stall = 1'b1;
		send_line(20);
		check(o_link_ready, 0);
		check(o_link_overflow, 1);
		stall = 1'b0;
		tick(80);
		check(o_link_ready, 1);
		check(o_link_overflow, 1);
		do_reset(1'b0);
		chk_on = 1'b1;
		tick(10);
		check(o_burnin, 1);
		nsym = 0;
		tick(2000);
		check(o_burnin, 1);
		check(nsym > 0, 1);
		finish_test();
	end
endmodule : tb_pal_autorefresh_lane_map
